// *** shared/acd_pkg.sv ***
/*
  Constants for the auxiliary clock select and divide block: register byte
  addresses, field positions, reset values, source indices and start-up counts.
  Assumes a 32-bit register address and 32-bit read data.
*/
`default_nettype none

package acd_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_TICK_DIV     = 32'h400480B0;
  localparam logic [31:0] ADDR_WDT_SEL      = 32'h400480D0;
  localparam logic [31:0] ADDR_WDT_UPD      = 32'h400480D4;
  localparam logic [31:0] ADDR_WDT_DIV      = 32'h400480D8;
  localparam logic [31:0] ADDR_CO_SEL       = 32'h400480E0;
  localparam logic [31:0] ADDR_CO_UPD       = 32'h400480E4;
  localparam logic [31:0] ADDR_CO_DIV       = 32'h400480E8;
  localparam logic [31:0] ADDR_CAP_LOW      = 32'h40048100;
  localparam logic [31:0] ADDR_CAP_HIGH     = 32'h40048104;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int DIV_W       = 8;
  localparam int SEL_W       = 2;
  localparam int UPD_BIT     = 0;
  localparam int CNT_W       = DIV_W + 1;
  localparam int CAP_LOW_W   = 32;
  localparam int CAP_HIGH_W  = 10;
  // Low capture: port 0 at 11:0, port 1 at 23:12, port 2 pins 0..7 at 31:24
  localparam int CAP_P0_LSB  = 0;
  localparam int CAP_P1_LSB  = 12;
  localparam int CAP_P2_LSB  = 24;
  // High capture: port 2 pins 8..11 at 3:0, port 3 pins 0..5 at 9:4
  localparam int CAP_P2H_LSB = 0;
  localparam int CAP_P3_LSB  = 4;
  localparam int PIN_W       = 42;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DIV_W-1:0] DIV_RST = 8'h00;
  localparam logic [SEL_W-1:0] SEL_RST = 2'h0;
  localparam logic             UPD_RST = 1'h0;

  // ----------------------------------------------------------------
  // Source indices into the synchronised source vector
  // ----------------------------------------------------------------
  localparam int SRC_N        = 4;
  localparam int SRC_IRC      = 0;
  localparam int SRC_SYS_OSC  = 1;
  localparam int SRC_WDT_OSC  = 2;
  localparam int SRC_MAIN     = 3;

  // Watchdog select codes
  localparam logic [SEL_W-1:0] WSEL_IRC  = 2'h0;
  localparam logic [SEL_W-1:0] WSEL_MAIN = 2'h1;
  localparam logic [SEL_W-1:0] WSEL_WOSC = 2'h2;

  // Clock output select codes
  localparam logic [SEL_W-1:0] CSEL_IRC  = 2'h0;
  localparam logic [SEL_W-1:0] CSEL_SOSC = 2'h1;
  localparam logic [SEL_W-1:0] CSEL_WOSC = 2'h2;
  localparam logic [SEL_W-1:0] CSEL_MAIN = 2'h3;

  // ----------------------------------------------------------------
  // Channels and start-up
  // ----------------------------------------------------------------
  localparam int CH_N    = 3;
  localparam int CH_TICK = 0;
  localparam int CH_WDT  = 1;
  localparam int CH_CO   = 2;
  // Enabled cycles after reset release before the pin levels are captured
  localparam logic [1:0] CAP_SETTLE = 2'h2;

endpackage

`default_nettype wire

// *** design/acd_clock_gen.sv ***
/*
  Auxiliary clock select and divide block: tick timer clock divider, watchdog
  and clock-output source multiplexers with update handshake and dividers,
  and the two reset-time pin capture registers.
  Assumes all source clocks are much slower than i_clock (below 100 MHz), as
  they are sampled and rebuilt in the i_clock domain; pins are asynchronous.
*/
// Design decision made here: the strobed register port.
// Contract
// - A tick divider of zero stops the tick clock, and 1 to 255 divide the main clock by it.
// - Watchdog source code 00 is the RC oscillator, 01 the main clock, 10 the watchdog one.
// - A new watchdog source is applied only on a low-to-high change of its update bit.
// - A watchdog divider of zero gates its clock, and 1 to 255 divide the chosen source.
// - Output source code 00 is RC, 01 system, 10 watchdog oscillator and 11 the main clock.
// - A new output source is applied only on a low-to-high change of its update bit.
// - An output divider of zero gates the pin clock, and 1 to 255 divide the chosen source.
// - The low capture register holds reset-time pin levels of ports 0, 1 and 2 pins 0 to 7.
// - Its layout is port 0 in bits 11:0, port 1 in 23:12 and port 2 pins 0 to 7 in 31:24.
// - The high capture register holds reset-time levels of port 2 pins 8 to 11 and port 3.
// - Its bits 3:0 are port 2 pins 8 to 11, bits 9:4 port 3 pins 0 to 5, the rest zero.
`timescale 1ns/1ps
`default_nettype none

module acd_clock_gen
(
  // Clock, reset, enable
  input  wire logic                          i_clock,
  input  wire logic                          i_rst,
  input  wire logic                          i_clk_en,
  // Register port
  input  wire logic [31:0]                   i_addr,
  input  wire logic [31:0]                   i_wdata,
  input  wire logic                          i_wr,
  input  wire logic                          i_rd,
  output logic      [31:0]                   o_rdata,
  // Source clocks
  input  wire logic                          i_irc_clk,
  input  wire logic                          i_sys_osc_clk,
  input  wire logic                          i_wdt_osc_clk,
  input  wire logic                          i_main_clk,
  // Pins sampled at reset
  input  wire logic [11:0]                   i_port0,
  input  wire logic [11:0]                   i_port1,
  input  wire logic [11:0]                   i_port2,
  input  wire logic [5:0]                    i_port3,
  // Generated clocks
  output logic                               o_tick_clk,
  output logic                               o_wdt_clk,
  output logic                               o_clkout
);

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic [acd_pkg::SRC_N-1:0] src_meta_q;
  logic [acd_pkg::SRC_N-1:0] src_sync_q;
  logic [acd_pkg::PIN_W-1:0] pin_meta_q;
  logic [acd_pkg::PIN_W-1:0] pin_sync_q;
  wire  [acd_pkg::SRC_N-1:0] src_raw;
  wire  [acd_pkg::PIN_W-1:0] pin_raw;

  assign src_raw = {i_main_clk, i_wdt_osc_clk, i_sys_osc_clk, i_irc_clk};
  assign pin_raw = {i_port3, i_port2, i_port1, i_port0};

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      src_meta_q <= '0;
      src_sync_q <= '0;
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end
    else if (i_clk_en)
    begin
      src_meta_q <= src_raw;
      src_sync_q <= src_meta_q;
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [acd_pkg::DIV_W-1:0]      tick_div_q;
  logic [acd_pkg::SEL_W-1:0]      wdt_sel_q;
  logic                           wdt_upd_q;
  logic [acd_pkg::DIV_W-1:0]      wdt_div_q;
  logic [acd_pkg::SEL_W-1:0]      co_sel_q;
  logic                           co_upd_q;
  logic [acd_pkg::DIV_W-1:0]      co_div_q;
  logic [acd_pkg::CAP_LOW_W-1:0]  cap_low_q;
  logic [acd_pkg::CAP_HIGH_W-1:0] cap_high_q;

  wire hit_tick_div = (i_addr == acd_pkg::ADDR_TICK_DIV);
  wire hit_wdt_sel  = (i_addr == acd_pkg::ADDR_WDT_SEL);
  wire hit_wdt_upd  = (i_addr == acd_pkg::ADDR_WDT_UPD);
  wire hit_wdt_div  = (i_addr == acd_pkg::ADDR_WDT_DIV);
  wire hit_co_sel   = (i_addr == acd_pkg::ADDR_CO_SEL);
  wire hit_co_upd   = (i_addr == acd_pkg::ADDR_CO_UPD);
  wire hit_co_div   = (i_addr == acd_pkg::ADDR_CO_DIV);
  wire hit_cap_low  = (i_addr == acd_pkg::ADDR_CAP_LOW);
  wire hit_cap_high = (i_addr == acd_pkg::ADDR_CAP_HIGH);

  wire wr_bit = i_wdata[acd_pkg::UPD_BIT];

  // Only a written one over a stored zero counts; a written zero just arms
  wire wdt_upd_rise = i_wr & hit_wdt_upd & wr_bit & ~wdt_upd_q;
  wire co_upd_rise  = i_wr & hit_co_upd & wr_bit & ~co_upd_q;

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      tick_div_q <= acd_pkg::DIV_RST;
      wdt_sel_q  <= acd_pkg::SEL_RST;
      wdt_upd_q  <= acd_pkg::UPD_RST;
      wdt_div_q  <= acd_pkg::DIV_RST;
      co_sel_q   <= acd_pkg::SEL_RST;
      co_upd_q   <= acd_pkg::UPD_RST;
      co_div_q   <= acd_pkg::DIV_RST;
    end
    else if (i_clk_en && i_wr)
    begin
      if (hit_tick_div)
        tick_div_q <= i_wdata[acd_pkg::DIV_W-1:0];
      if (hit_wdt_sel)
        wdt_sel_q <= i_wdata[acd_pkg::SEL_W-1:0];
      if (hit_wdt_upd)
        wdt_upd_q <= wr_bit;
      if (hit_wdt_div)
        wdt_div_q <= i_wdata[acd_pkg::DIV_W-1:0];
      if (hit_co_sel)
        co_sel_q <= i_wdata[acd_pkg::SEL_W-1:0];
      if (hit_co_upd)
        co_upd_q <= wr_bit;
      if (hit_co_div)
        co_div_q <= i_wdata[acd_pkg::DIV_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Reset-time pin capture
  // ----------------------------------------------------------------
  // The pins need two enabled cycles to clear the synchroniser, so the
  // capture is taken once, after that settle time, and never again.
  logic [1:0] cap_wait_q;
  logic       cap_done_q;
  wire        cap_take = ~cap_done_q & (cap_wait_q == acd_pkg::CAP_SETTLE);

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      cap_wait_q <= 2'h0;
      cap_done_q <= 1'b0;
      cap_low_q  <= '0;
      cap_high_q <= '0;
    end
    else if (i_clk_en)
    begin
      if (!cap_done_q && !cap_take)
        cap_wait_q <= cap_wait_q + 2'h1;
      if (cap_take)
      begin
        cap_done_q <= 1'b1;
        cap_low_q[acd_pkg::CAP_P0_LSB +: 12] <= pin_sync_q[11:0];
        cap_low_q[acd_pkg::CAP_P1_LSB +: 12] <= pin_sync_q[23:12];
        cap_low_q[acd_pkg::CAP_P2_LSB +: 8]  <= pin_sync_q[31:24];
        cap_high_q[acd_pkg::CAP_P2H_LSB +: 4] <= pin_sync_q[35:32];
        cap_high_q[acd_pkg::CAP_P3_LSB +: 6]  <= pin_sync_q[41:36];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [31:0] rdata_q;
  wire  [31:0] rd_word =
    hit_tick_div ? {24'h0, tick_div_q} :
    hit_wdt_sel  ? {30'h0, wdt_sel_q} :
    hit_wdt_upd  ? {31'h0, wdt_upd_q} :
    hit_wdt_div  ? {24'h0, wdt_div_q} :
    hit_co_sel   ? {30'h0, co_sel_q} :
    hit_co_upd   ? {31'h0, co_upd_q} :
    hit_co_div   ? {24'h0, co_div_q} :
    hit_cap_low  ? cap_low_q :
    hit_cap_high ? {22'h0, cap_high_q} :
    32'h00000000;

  // Capture registers have no write decode, so they stay read-only
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      rdata_q <= 32'h00000000;
    else if (i_clk_en)
      rdata_q <= i_rd ? rd_word : 32'h00000000;
  end

  assign o_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  // Reserved watchdog code gives no clock at all
  function automatic logic wdt_src(input logic [1:0] s, input logic [3:0] v);
    unique case (s)
      acd_pkg::WSEL_IRC:  wdt_src = v[acd_pkg::SRC_IRC];
      acd_pkg::WSEL_MAIN: wdt_src = v[acd_pkg::SRC_MAIN];
      acd_pkg::WSEL_WOSC: wdt_src = v[acd_pkg::SRC_WDT_OSC];
      default:            wdt_src = 1'b0;
    endcase
  endfunction

  function automatic logic co_src(input logic [1:0] s, input logic [3:0] v);
    unique case (s)
      acd_pkg::CSEL_IRC:  co_src = v[acd_pkg::SRC_IRC];
      acd_pkg::CSEL_SOSC: co_src = v[acd_pkg::SRC_SYS_OSC];
      acd_pkg::CSEL_WOSC: co_src = v[acd_pkg::SRC_WDT_OSC];
      acd_pkg::CSEL_MAIN: co_src = v[acd_pkg::SRC_MAIN];
    endcase
  endfunction

  // Pending selections, raised by the update handshake
  logic [acd_pkg::SEL_W-1:0] wdt_pend_sel_q;
  logic [acd_pkg::SEL_W-1:0] co_pend_sel_q;
  logic                      wdt_pend_q;
  logic                      co_pend_q;

  wire  [acd_pkg::SEL_W-1:0] sel_act_q [acd_pkg::CH_N];
  logic [acd_pkg::DIV_W-1:0] div_req   [acd_pkg::CH_N];
  logic [acd_pkg::SEL_W-1:0] sel_new   [acd_pkg::CH_N];
  wire  [acd_pkg::CH_N-1:0]  sel_pend;
  wire  [acd_pkg::CH_N-1:0]  lvl_act;
  wire  [acd_pkg::CH_N-1:0]  lvl_new;
  wire  [acd_pkg::CH_N-1:0]  apply;

  assign div_req[acd_pkg::CH_TICK] = tick_div_q;
  assign div_req[acd_pkg::CH_WDT]  = wdt_div_q;
  assign div_req[acd_pkg::CH_CO]   = co_div_q;
  assign sel_new[acd_pkg::CH_TICK] = acd_pkg::SEL_RST;
  assign sel_new[acd_pkg::CH_WDT]  = wdt_pend_sel_q;
  assign sel_new[acd_pkg::CH_CO]   = co_pend_sel_q;
  assign sel_pend = {co_pend_q, wdt_pend_q, 1'b0};

  assign lvl_act[acd_pkg::CH_TICK] = src_sync_q[acd_pkg::SRC_MAIN];
  assign lvl_new[acd_pkg::CH_TICK] = src_sync_q[acd_pkg::SRC_MAIN];
  assign lvl_act[acd_pkg::CH_WDT]  = wdt_src(sel_act_q[acd_pkg::CH_WDT], src_sync_q);
  assign lvl_new[acd_pkg::CH_WDT]  = wdt_src(wdt_pend_sel_q, src_sync_q);
  assign lvl_act[acd_pkg::CH_CO]   = co_src(sel_act_q[acd_pkg::CH_CO], src_sync_q);
  assign lvl_new[acd_pkg::CH_CO]   = co_src(co_pend_sel_q, src_sync_q);

  // A new rise while an older request is applied keeps the request alive
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      wdt_pend_q     <= 1'b0;
      co_pend_q      <= 1'b0;
      wdt_pend_sel_q <= acd_pkg::SEL_RST;
      co_pend_sel_q  <= acd_pkg::SEL_RST;
    end
    else if (i_clk_en)
    begin
      if (wdt_upd_rise)
      begin
        wdt_pend_q     <= 1'b1;
        wdt_pend_sel_q <= wdt_sel_q;
      end
      else if (apply[acd_pkg::CH_WDT])
        wdt_pend_q <= 1'b0;
      if (co_upd_rise)
      begin
        co_pend_q     <= 1'b1;
        co_pend_sel_q <= co_sel_q;
      end
      else if (apply[acd_pkg::CH_CO])
        co_pend_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Dividers
  // ----------------------------------------------------------------
  // Each source edge, rising or falling, advances a half-period count
  // 0..2N-1; the output is high for the first N, so any N keeps 50% duty
  // and N = 1 follows the source. Changes wait for the end of a low phase, or apply at once while gated or on a reserved watchdog source.
  wire  [acd_pkg::CH_N-1:0] out_q;

  genvar c;
  generate
    for (c = 0; c < acd_pkg::CH_N; c++)
    begin : g_div
      logic [acd_pkg::DIV_W-1:0] div_act_q;
      logic [acd_pkg::SEL_W-1:0] sel_q;
      logic [acd_pkg::CNT_W-1:0] cnt_q;
      logic                      prev_q;
      logic                      clk_q;

      wire                       gated   = (div_act_q == '0);
      wire                       src_edg = (lvl_act[c] != prev_q);
      wire [acd_pkg::CNT_W-1:0]  last    = {div_act_q, 1'b0} - 9'h001;
      wire                       at_end  = src_edg & (cnt_q == last);
      wire                       changed = (div_req[c] != div_act_q) | sel_pend[c];
      wire [acd_pkg::CNT_W-1:0]  cnt_nx  = at_end ? 9'h000 : cnt_q + 9'h001;

      // A reserved watchdog source has no phase end to wait for
      wire                       stuck   = (c == acd_pkg::CH_WDT) & (&sel_q);

      assign apply[c] = changed & (gated | at_end | stuck);
      assign sel_act_q[c] = sel_q;
      assign out_q[c]     = clk_q;

      always_ff @(posedge i_clock or posedge i_rst)
      begin
        if (i_rst)
        begin
          div_act_q    <= acd_pkg::DIV_RST;
          sel_q        <= acd_pkg::SEL_RST;
          cnt_q        <= '0;
          prev_q       <= 1'b0;
          clk_q        <= 1'b0;
        end
        else if (i_clk_en)
        begin
          if (apply[c])
          begin
            // Restart in the low phase so the first high lasts a full N
            div_act_q    <= div_req[c];
            sel_q        <= sel_pend[c] ? sel_new[c] : sel_q;
            prev_q       <= sel_pend[c] ? lvl_new[c] : lvl_act[c];
            cnt_q        <= {1'b0, div_req[c]};
            clk_q        <= 1'b0;
          end
          else
          begin
            prev_q <= lvl_act[c];
            if (!gated && src_edg)
            begin
              cnt_q    <= cnt_nx;
              clk_q    <= (cnt_nx < {1'b0, div_act_q});
            end
          end
        end
      end
    end
  endgenerate

  assign o_tick_clk = out_q[acd_pkg::CH_TICK];
  assign o_wdt_clk  = out_q[acd_pkg::CH_WDT];
  assign o_clkout   = out_q[acd_pkg::CH_CO];

endmodule

`default_nettype wire

// *** sim/acd_clock_gen_props.sv ***
/*
  Checker for the auxiliary clock block: register read-back, read-data idle
  level, reserved bits and gated clock outputs.
  Assumes it is bound to acd_clock_gen and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none

module acd_clock_gen_props
(
  // Clock, reset, enable
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_clk_en,
  // Register port
  input  wire logic [31:0] i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic [31:0] o_rdata,
  // Generated clocks
  input  wire logic        o_tick_clk,
  input  wire logic        o_wdt_clk,
  input  wire logic        o_clkout
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);

  // ----------------------------------------------------------------
  // Shadow copies of the divider fields
  // ----------------------------------------------------------------
  wire logic       wr_en = i_clk_en & i_wr;
  wire logic       rd_en = i_clk_en & i_rd;
  logic      [7:0] tick_q;
  logic      [7:0] wdt_q;
  logic      [7:0] co_q;

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      tick_q <= 8'h00;
      wdt_q  <= 8'h00;
      co_q   <= 8'h00;
    end
    else if (wr_en)
    begin
      if (i_addr == acd_pkg::ADDR_TICK_DIV) tick_q <= i_wdata[7:0];
      if (i_addr == acd_pkg::ADDR_WDT_DIV) wdt_q <= i_wdata[7:0];
      if (i_addr == acd_pkg::ADDR_CO_DIV) co_q <= i_wdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // A gated output that is low may not rise again; the one-cycle lag allows a pending change
  AST_TICK_GATED : assert property (tick_q == 8'h00 && $past(tick_q) == 8'h00
    && i_clk_en && !o_tick_clk |=> !o_tick_clk) else $error("tick clock rose while gated");
  AST_WDT_GATED : assert property (wdt_q == 8'h00 && $past(wdt_q) == 8'h00
    && i_clk_en && !o_wdt_clk |=> !o_wdt_clk) else $error("watchdog clock rose while gated");
  AST_CO_GATED : assert property (co_q == 8'h00 && $past(co_q) == 8'h00
    && i_clk_en && !o_clkout |=> !o_clkout) else $error("output clock rose while gated");
  AST_TICK_RDBACK : assert property ((wr_en && i_addr == acd_pkg::ADDR_TICK_DIV) ##1
    (rd_en && i_addr == acd_pkg::ADDR_TICK_DIV) |=> o_rdata == {24'h0, $past(i_wdata[7:0], 2)})
    else $error("tick divider read-back wrong");
  AST_WSEL_RDBACK : assert property ((wr_en && i_addr == acd_pkg::ADDR_WDT_SEL) ##1
    (rd_en && i_addr == acd_pkg::ADDR_WDT_SEL) |=> o_rdata == {30'h0, $past(i_wdata[1:0], 2)})
    else $error("watchdog select read-back wrong");
  AST_CSEL_RDBACK : assert property ((wr_en && i_addr == acd_pkg::ADDR_CO_SEL) ##1
    (rd_en && i_addr == acd_pkg::ADDR_CO_SEL) |=> o_rdata == {30'h0, $past(i_wdata[1:0], 2)})
    else $error("output select read-back wrong");
  AST_UPD_UPPER : assert property (rd_en && (i_addr == acd_pkg::ADDR_WDT_UPD
    || i_addr == acd_pkg::ADDR_CO_UPD) |=> o_rdata[31:1] == 31'h0)
    else $error("update register upper bits not zero");
  AST_CAP_HIGH_RSVD : assert property (rd_en && i_addr == acd_pkg::ADDR_CAP_HIGH
    |=> o_rdata[31:10] == 22'h0) else $error("high capture reserved bits not zero");
  AST_RD_IDLE : assert property (i_clk_en && !i_rd |=> o_rdata == 32'h0)
    else $error("read data not zero outside a read");
  AST_UNMAPPED : assert property (rd_en && i_addr == 32'h400480DC |=> o_rdata == 32'h0)
    else $error("unmapped read not zero");

  COV_CAP_READ : cover property (rd_en && i_addr == acd_pkg::ADDR_CAP_LOW);
  COV_WDT_RISE : cover property ($rose(o_wdt_clk));
  COV_CO_RISE : cover property ($rose(o_clkout));
endmodule

bind acd_clock_gen acd_clock_gen_props u_props
(
  .i_clock, .i_rst, .i_clk_en, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
  .o_tick_clk, .o_wdt_clk, .o_clkout
);

`default_nettype wire

// *** sim/acd_clock_gen_tb_top.sv ***
/*
  Self-checking bench for the auxiliary clock block: register table, dividers,
  source selection with update handshake, gating and pin capture.
  Assumes source clocks are made here in step with i_clock, so periods are exact.
*/
`timescale 1ns/1ps
`default_nettype none

module acd_clock_gen_tb_top;
  typedef struct packed {logic [31:0] addr; logic [31:0] wdata;
                         logic [31:0] rst; logic [31:0] exp;} acd_row_t;
  localparam logic [11:0] P0 = 12'hA5C, P1 = 12'h3E1, P2 = 12'h9B7;
  localparam logic [5:0]  P3 = 6'h2D;
  localparam logic [31:0] CAP_LO = {P2[7:0], P1, P0};
  localparam logic [31:0] CAP_HI = {22'h0, P3, P2[11:8]};
  // Source periods in i_clock cycles
  localparam int MAIN_P = 8, IRC_P = 16, SYS_P = 32, WOSC_P = 64, LIM = 3000;
  localparam acd_row_t ROWS [10] = '{
    '{acd_pkg::ADDR_TICK_DIV, 32'hFFFFFF05, 32'h0, 32'h05},
    '{acd_pkg::ADDR_WDT_SEL, 32'hFFFFFFFE, 32'h0, 32'h2},
    '{acd_pkg::ADDR_WDT_UPD, 32'hFFFFFFFF, 32'h0, 32'h1},
    '{acd_pkg::ADDR_WDT_DIV, 32'hFFFFFF03, 32'h0, 32'h03},
    '{acd_pkg::ADDR_CO_SEL, 32'hFFFFFFFD, 32'h0, 32'h1},
    '{acd_pkg::ADDR_CO_UPD, 32'hFFFFFFFF, 32'h0, 32'h1},
    '{acd_pkg::ADDR_CO_DIV, 32'hFFFFFF02, 32'h0, 32'h02},
    '{acd_pkg::ADDR_CAP_LOW, 32'hFFFFFFFF, CAP_LO, CAP_LO},
    '{acd_pkg::ADDR_CAP_HIGH, 32'hFFFFFFFF, CAP_HI, CAP_HI},
    '{32'h400480DC, 32'hFFFFFFFF, 32'h0, 32'h0}};
  logic        i_clock, i_rst, i_clk_en, i_wr, i_rd;
  logic [31:0] i_addr, i_wdata, o_rdata, q;
  logic        i_irc_clk, i_sys_osc_clk, i_wdt_osc_clk, i_main_clk;
  logic [11:0] i_port0, i_port1, i_port2;
  logic [5:0]  i_port3;
  logic        o_tick_clk, o_wdt_clk, o_clkout;
  logic [7:0]  cyc;
  int          bad_count, compares, p, old;
  int          tdiv [3] = '{255, 1, 3};
  int          wcode [3] = '{1, 2, 0};
  int          wper [3] = '{MAIN_P, WOSC_P, IRC_P};
  int          ccode [4] = '{1, 2, 3, 0};
  int          cper [4] = '{2 * SYS_P, 2 * WOSC_P, 2 * MAIN_P, 2 * IRC_P};

  acd_clock_gen uut (.i_clock, .i_rst, .i_clk_en, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_irc_clk, .i_sys_osc_clk, .i_wdt_osc_clk, .i_main_clk, .i_port0, .i_port1, .i_port2,
    .i_port3, .o_tick_clk, .o_wdt_clk, .o_clkout);

  initial
  begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  // Sources derived from one counter so every period is a whole cycle count
  always @(posedge i_clock)
  begin
    cyc <= cyc + 8'h01;
    i_main_clk <= cyc[2];
    i_irc_clk <= cyc[3];
    i_sys_osc_clk <= cyc[4];
    i_wdt_osc_clk <= cyc[5];
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_num(input int got, input int exp);
    compares++;
    if (got != exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    if (bad_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Tasks start just after a rising edge and end on one, strobes already low
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
    @(posedge i_clock);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    @(posedge i_clock);
    d = o_rdata;
  endtask

  task automatic wr_rd(input logic [31:0] a, input logic [31:0] v, output logic [31:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clock);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    @(posedge i_clock);
    d = o_rdata;
  endtask

  function automatic logic sig(input int ch);
    return (ch == 0) ? o_tick_clk : ((ch == 1) ? o_wdt_clk : o_clkout);
  endfunction

  task automatic wait_rise(input int ch, output int n);
    logic prev;
    prev = sig(ch);
    n = 0;
    repeat (LIM)
    begin
      @(posedge i_clock);
      n++;
      if (sig(ch) === 1'b1 && prev === 1'b0) return;
      prev = sig(ch);
    end
    bad_count++;
    give_verdict();
  endtask

  // Two rises are skipped so a pending switch has landed before measuring
  task automatic period(input int ch, output int per);
    int n;
    wait_rise(ch, n);
    wait_rise(ch, n);
    wait_rise(ch, per);
  endtask

  task automatic stays_low(input int ch);
    int hits;
    hits = 0;
    repeat (600) @(posedge i_clock);
    repeat (600)
    begin
      @(posedge i_clock);
      if (sig(ch) !== 1'b0) hits++;
    end
    chk_num(hits, 0);
  endtask

  task automatic sel_test(input int ch, input logic [31:0] sa, input logic [31:0] ua,
                          input int code, input int oldp, input int newp);
    int per;
    wr(sa, code);
    wr(ua, 32'h1);
    period(ch, per);
    chk_num(per, oldp);
    wr(ua, 32'h0);
    period(ch, per);
    chk_num(per, oldp);
    wr(ua, 32'h1);
    period(ch, per);
    chk_num(per, newp);
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    {i_rst, i_clk_en} = 2'h3;
    {i_wr, i_rd, i_addr, i_wdata, cyc, bad_count, compares} = '0;
    {i_irc_clk, i_sys_osc_clk, i_wdt_osc_clk, i_main_clk} = 4'h0;
    {i_port0, i_port1, i_port2, i_port3} = {P0, P1, P2, P3};
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    for (int c = 0; c < 3; c++) stays_low(c);
    {i_port0, i_port1, i_port2, i_port3} <= ~{P0, P1, P2, P3};
    foreach (ROWS[i])
    begin
      rd(ROWS[i].addr, q);
      chk_word(q, ROWS[i].rst);
      wr_rd(ROWS[i].addr, ROWS[i].wdata, q);
      chk_word(q, ROWS[i].exp);
    end
    foreach (tdiv[i])
    begin
      wr(acd_pkg::ADDR_TICK_DIV, tdiv[i]);
      period(0, p);
      chk_num(p, tdiv[i] * MAIN_P);
    end
    wr(acd_pkg::ADDR_TICK_DIV, 32'h0);
    stays_low(0);
    wr(acd_pkg::ADDR_WDT_DIV, 32'h1);
    wr(acd_pkg::ADDR_WDT_SEL, 32'h0);
    wr(acd_pkg::ADDR_WDT_UPD, 32'h0);
    wr(acd_pkg::ADDR_WDT_UPD, 32'h1);
    old = IRC_P;
    foreach (wcode[i])
    begin
      sel_test(1, acd_pkg::ADDR_WDT_SEL, acd_pkg::ADDR_WDT_UPD, wcode[i], old, wper[i]);
      old = wper[i];
    end
    wr(acd_pkg::ADDR_WDT_DIV, 32'h0);
    stays_low(1);
    wr(acd_pkg::ADDR_WDT_DIV, 32'h1);
    wr(acd_pkg::ADDR_WDT_SEL, 32'h3);
    wr(acd_pkg::ADDR_WDT_UPD, 32'h0);
    wr(acd_pkg::ADDR_WDT_UPD, 32'h1);
    stays_low(1);
    wr(acd_pkg::ADDR_WDT_SEL, 32'h1);
    wr(acd_pkg::ADDR_WDT_UPD, 32'h0);
    wr(acd_pkg::ADDR_WDT_UPD, 32'h1);
    period(1, p);
    chk_num(p, MAIN_P);
    wr(acd_pkg::ADDR_CO_DIV, 32'h2);
    wr(acd_pkg::ADDR_CO_SEL, 32'h0);
    wr(acd_pkg::ADDR_CO_UPD, 32'h0);
    wr(acd_pkg::ADDR_CO_UPD, 32'h1);
    old = 2 * IRC_P;
    foreach (ccode[i])
    begin
      sel_test(2, acd_pkg::ADDR_CO_SEL, acd_pkg::ADDR_CO_UPD, ccode[i], old, cper[i]);
      old = cper[i];
    end
    wr(acd_pkg::ADDR_CO_DIV, 32'h0);
    stays_low(2);
    // A strobe while the enable is low must be ignored
    i_clk_en <= 1'b0;
    wr(acd_pkg::ADDR_TICK_DIV, 32'h7);
    i_clk_en <= 1'b1;
    rd(acd_pkg::ADDR_TICK_DIV, q);
    chk_word(q, 32'h0);
    // Second power-on reset takes the new pin levels
    i_rst <= 1'b1;
    @(posedge i_clock);
    i_rst <= 1'b0;
    repeat (6) @(posedge i_clock);
    rd(acd_pkg::ADDR_CAP_LOW, q);
    chk_word(q, ~CAP_LO);
    rd(acd_pkg::ADDR_CAP_HIGH, q);
    chk_word(q, CAP_HI ^ 32'h3FF);
    rd(acd_pkg::ADDR_CO_SEL, q);
    chk_word(q, 32'h0);
    give_verdict();
  end
endmodule

`default_nettype wire
